// ### shared/mho_pkg.sv
// shared constants for the high multiply and logic datapath
package mho_pkg;
   // instruction field positions
   localparam int FLD_A_HI = 31;
   localparam int FLD_A_LO = 27;
   localparam int FLD_B_HI = 26;
   localparam int FLD_B_LO = 22;
   localparam int FLD_C_HI = 21;
   localparam int FLD_C_LO = 17;
   localparam int FLD_X_HI = 16;
   localparam int FLD_X_LO = 11;
   localparam int FLD_Z_HI = 10;
   localparam int FLD_Z_LO = 6;
   localparam int FLD_OP_HI = 5;
   localparam int FLD_OP_LO = 0;
   localparam int FLD_IMM_HI = 21;
   localparam int FLD_IMM_LO = 6;
   // primary opcodes
   localparam logic [5:0] OP_RTYPE = 6'h3a;
   localparam logic [5:0] OP_ORHI = 6'h34;
   // extended opcodes
   localparam logic [5:0] X_MULXSS = 6'h1f;
   localparam logic [5:0] X_MULXSU = 6'h17;
   localparam logic [5:0] X_MULXUU = 6'h07;
   localparam logic [5:0] X_MUL = 6'h27;
   localparam logic [5:0] X_NEXTPC = 6'h1c;
   localparam logic [5:0] X_NOR = 6'h06;
   localparam logic [5:0] X_OR = 6'h16;
   localparam logic [5:0] X_ADD = 6'h31;
   localparam logic [31:0] PC_STEP = 32'h0000_0004;
   localparam logic [15:0] HALF_ZERO = 16'h0000;
   localparam logic [31:0] WORD_ZERO = 32'h0000_0000;
   localparam logic [4:0] REG_ZERO = 5'h00;
   localparam int NUM_REGS = 32;
endpackage : mho_pkg

// ### rtl/mho_datapath.sv
// decode, execute and register file for high multiply and logic ops
`timescale 1ns/1ps
module mho_datapath #(
   parameter bit HAS_MUL = 1'b1
) (
   input wire logic core_clk_in,
   input wire logic rst_n_in,
   input wire logic instr_valid_in,
   input wire logic [31:0] instr_in,
   input wire logic [31:0] pc_in,
   input wire logic [4:0] rd_index_in,
   output logic [31:0] rd_data_out,
   output logic done_out,
   output logic unimpl_exc_out,
   output logic illegal_out,
   output logic wr_en_out,
   output logic [4:0] wr_index_out,
   output logic [31:0] wr_data_out
);
   typedef enum logic [2:0] {
      MHO_IDLE = 3'b001,
      MHO_EXEC = 3'b010,
      MHO_DONE = 3'b100
   } mho_state_t;

   mho_state_t state;
   logic [31:0] regs [mho_pkg::NUM_REGS];
   logic [31:0] instr;
   logic [31:0] pc;
   logic [4:0] first_source_operand;
   logic [4:0] second_source_operand;
   logic [4:0] destination_operand;
   logic [5:0] ext_op;
   logic [5:0] prim_op;
   logic [15:0] immediate_halfword_field;
   logic [31:0] src_a;
   logic [31:0] src_b;
   logic signed [65:0] product;
   logic [31:0] next_result;
   logic [4:0] next_dest;
   logic next_write;
   logic next_unimpl;
   logic next_illegal;
   logic is_mulx;
   logic is_rtype;
   logic is_orhi;
   logic take_instr;
   logic in_exec;
   logic [32:0] mul_a;
   logic [32:0] mul_b;
   mho_state_t next_state;
   genvar g;

   // field extraction for both formats
   assign first_source_operand =
      instr[mho_pkg::FLD_A_HI:mho_pkg::FLD_A_LO];
   assign second_source_operand =
      instr[mho_pkg::FLD_B_HI:mho_pkg::FLD_B_LO];
   assign destination_operand =
      instr[mho_pkg::FLD_C_HI:mho_pkg::FLD_C_LO];
   assign ext_op = instr[mho_pkg::FLD_X_HI:mho_pkg::FLD_X_LO];
   assign prim_op = instr[mho_pkg::FLD_OP_HI:mho_pkg::FLD_OP_LO];
   assign immediate_halfword_field =
      instr[mho_pkg::FLD_IMM_HI:mho_pkg::FLD_IMM_LO];

   // register zero always reads as zero
   assign src_a = (first_source_operand == mho_pkg::REG_ZERO) ?
      mho_pkg::WORD_ZERO : regs[first_source_operand];
   assign src_b = (second_source_operand == mho_pkg::REG_ZERO) ?
      mho_pkg::WORD_ZERO : regs[second_source_operand];

   // opcode classes
   assign is_rtype = (prim_op == mho_pkg::OP_RTYPE);
   assign is_orhi = (prim_op == mho_pkg::OP_ORHI);
   assign is_mulx = is_rtype && ((ext_op == mho_pkg::X_MULXSS) ||
      (ext_op == mho_pkg::X_MULXSU) ||
      (ext_op == mho_pkg::X_MULXUU));

   // handshake qualifiers
   assign take_instr = (state == MHO_IDLE) && instr_valid_in;
   assign in_exec = (state == MHO_EXEC);

   // one 33x33 signed multiplier covers all three signedness cases,
   // traded against three separate arrays
   always_comb begin
      mul_a = {1'b0, src_a};
      case (ext_op)
         mho_pkg::X_MULXSS: begin
            mul_a = {src_a[31], src_a};
         end
         mho_pkg::X_MULXSU: begin
            mul_a = {src_a[31], src_a};
         end
         default: begin
            mul_a = {1'b0, src_a};
         end
      endcase
   end

   // only the signed by signed form extends the second operand
   always_comb begin
      mul_b = {1'b0, src_b};
      if (ext_op == mho_pkg::X_MULXSS) begin
         mul_b = {src_b[31], src_b};
      end
   end

   // both operands extended to the full product width first
   assign product = $signed({{33{mul_a[32]}}, mul_a}) *
      $signed({{33{mul_b[32]}}, mul_b});

   always_comb begin
      next_result = mho_pkg::WORD_ZERO;
      next_dest = destination_operand;
      next_write = 1'b0;
      next_unimpl = 1'b0;
      next_illegal = 1'b0;
      if (is_orhi) begin
         next_dest = second_source_operand;
         next_result = src_a |
            {immediate_halfword_field, mho_pkg::HALF_ZERO};
         next_write = 1'b1;
      end else if (is_rtype) begin
         case (ext_op)
            mho_pkg::X_MULXSS,
            mho_pkg::X_MULXSU,
            mho_pkg::X_MULXUU,
            mho_pkg::X_MUL: begin
               // one product feeds both halves
               if (is_mulx) begin
                  next_result = product[63:32];
               end else begin
                  next_result = product[31:0];
               end
               // without the multiplier nothing lands in the file
               next_write = HAS_MUL;
               next_unimpl = !HAS_MUL;
            end
            mho_pkg::X_NEXTPC: begin
               next_result = pc + mho_pkg::PC_STEP;
               next_write = 1'b1;
            end
            mho_pkg::X_NOR: begin
               next_result = ~(src_a | src_b);
               next_write = 1'b1;
            end
            mho_pkg::X_OR: begin
               next_result = src_a | src_b;
               next_write = 1'b1;
            end
            mho_pkg::X_ADD: begin
               // nop is this add with all indices zero
               next_result = src_a + src_b;
               next_write = 1'b1;
            end
            default: next_illegal = 1'b1;
         endcase
      end else begin
         next_illegal = 1'b1;
      end
      // a zero destination swallows the result
      if (next_dest == mho_pkg::REG_ZERO) begin
         next_write = 1'b0;
      end
   end

   // sequencer: capture, execute, report; valid is ignored while busy
   always_comb begin
      next_state = state;
      case (state)
         MHO_IDLE: begin
            if (instr_valid_in) begin
               next_state = MHO_EXEC;
            end
         end
         MHO_EXEC: begin
            next_state = MHO_DONE;
         end
         MHO_DONE: begin
            next_state = MHO_IDLE;
         end
         default: begin
            next_state = MHO_IDLE;
         end
      endcase
   end

   always_ff @(posedge core_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         state <= MHO_IDLE;
      end else begin
         state <= next_state;
      end
   end

   // word and address are held for the whole execute window
   always_ff @(posedge core_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         instr <= mho_pkg::WORD_ZERO;
      end else if (take_instr) begin
         instr <= instr_in;
      end
   end

   always_ff @(posedge core_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         pc <= mho_pkg::WORD_ZERO;
      end else if (take_instr) begin
         pc <= pc_in;
      end
   end

   // completion pulse trails execute by one edge
   always_ff @(posedge core_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         done_out <= 1'b0;
      end else begin
         done_out <= in_exec;
      end
   end

   // exception flags share the completion timing
   always_ff @(posedge core_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         unimpl_exc_out <= 1'b0;
      end else begin
         unimpl_exc_out <= in_exec && next_unimpl;
      end
   end

   always_ff @(posedge core_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         illegal_out <= 1'b0;
      end else begin
         illegal_out <= in_exec && next_illegal;
      end
   end

   // suppressed writes still complete; index and data still load, only the enable stays low
   always_ff @(posedge core_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         wr_en_out <= 1'b0;
      end else begin
         wr_en_out <= in_exec && next_write;
      end
   end

   // index and data hold until the next completion
   always_ff @(posedge core_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         wr_index_out <= mho_pkg::REG_ZERO;
      end else if (in_exec) begin
         wr_index_out <= next_dest;
      end
   end

   always_ff @(posedge core_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         wr_data_out <= mho_pkg::WORD_ZERO;
      end else if (in_exec) begin
         wr_data_out <= next_result;
      end
   end

   // register file, one word per entry; entry zero never gets a
   // write enable, so it stays at its reset value
   generate
      for (g = 0; g < mho_pkg::NUM_REGS; g++) begin : g_reg
         always_ff @(posedge core_clk_in or negedge rst_n_in) begin
            if (!rst_n_in) begin
               regs[g] <= mho_pkg::WORD_ZERO;
            end else if (in_exec && next_write &&
               (next_dest == 5'(g))) begin
               regs[g] <= next_result;
            end
         end
      end
   endgenerate

   // observe port, one edge behind the index
   always_ff @(posedge core_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         rd_data_out <= mho_pkg::WORD_ZERO;
      end else begin
         rd_data_out <= (rd_index_in == mho_pkg::REG_ZERO) ?
            mho_pkg::WORD_ZERO : regs[rd_index_in];
      end
   end
endmodule // mho_datapath

// ### testbench/mho_datapath_asserts.sv
// port checker for the high multiply and logic datapath
`timescale 1ns/1ps
module mho_datapath_asserts (
   input wire logic core_clk_in,
   input wire logic rst_n_in,
   input wire logic instr_valid_in,
   input wire logic [31:0] instr_in,
   input wire logic [31:0] pc_in,
   input wire logic [4:0] rd_index_in,
   input wire logic [31:0] rd_data_out,
   input wire logic done_out,
   input wire logic unimpl_exc_out,
   input wire logic illegal_out,
   input wire logic wr_en_out,
   input wire logic [4:0] wr_index_out,
   input wire logic [31:0] wr_data_out
);
   logic [1:0] busy;
   logic take, rt;
   assign take = instr_valid_in && busy == 2'h0;
   assign rt = instr_in[5:0] == mho_pkg::OP_RTYPE;
   // own copy of the busy window, the state is hidden
   always_ff @(posedge core_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) busy <= 2'h0;
      else if (take) busy <= 2'h2;
      else if (busy != 2'h0) busy <= busy - 2'h1;
   end
   default clocking @(posedge core_clk_in); endclocking
   default disable iff (!rst_n_in);
   property p_lat; take |=> !done_out ##1 done_out ##1 !done_out; endproperty
   a_lat: assert property (p_lat) else $error("done late");
   property p_flg; wr_en_out || illegal_out |-> done_out; endproperty
   a_flg: assert property (p_flg) else $error("stray flag");
   property p_zero; wr_en_out |-> wr_index_out != 5'h00; endproperty
   a_zero: assert property (p_zero) else $error("r0 write");
   property p_exc; unimpl_exc_out |-> done_out && !wr_en_out; endproperty
   a_exc: assert property (p_exc) else $error("exc wrote");
   property p_rd0; rd_index_in == 5'h00 |=> rd_data_out == 32'h0; endproperty
   a_rd0: assert property (p_rd0) else $error("r0 nonzero");
   property p_nxt; take && rt && instr_in[16:11] == mho_pkg::X_NEXTPC
      && instr_in[21:17] != 5'h00 |-> ##2 wr_en_out
      && wr_data_out == $past(pc_in, 2) + mho_pkg::PC_STEP; endproperty
   a_nxt: assert property (p_nxt) else $error("next addr");
   property p_hi; take && instr_in[5:0] == mho_pkg::OP_ORHI
      && instr_in[26:22] != 5'h00 |-> ##2 wr_en_out
      && wr_index_out == $past(instr_in[26:22], 2)
      && (wr_data_out[31:16] & $past(instr_in[21:6], 2))
      == $past(instr_in[21:6], 2); endproperty
   a_hi: assert property (p_hi) else $error("high or");
   // a nop word leaves no write behind
   property p_nop; take && instr_in == {15'h0, mho_pkg::X_ADD, 5'h00,
      mho_pkg::OP_RTYPE} |-> ##2 done_out && !wr_en_out; endproperty
   a_nop: assert property (p_nop) else $error("nop wrote");
endmodule // mho_datapath_asserts
bind mho_datapath mho_datapath_asserts u_chk (.*);

// ### testbench/tb_mul_high_and_logic_ops.sv
// self-checking bench for the high multiply and logic datapath
`timescale 1ns/1ps
module tb_mul_high_and_logic_ops;
   logic core_clk_in = 1'b0;
   logic rst_n_in = 1'b0;
   logic instr_valid_in = 1'b0;
   logic [31:0] instr_in = 32'h0;
   logic [31:0] pc_in = 32'h0;
   logic [4:0] rd_index_in = 5'h00;
   logic [31:0] rd_data_out, wr_data_out;
   logic [4:0] wr_index_out;
   logic done_out, unimpl_exc_out, illegal_out, wr_en_out;
   logic nm_done_out, nm_unimpl_exc_out, nm_wr_en_out;
   int err_total = 0;
   int total_checks = 0;
   always #25 core_clk_in = ~core_clk_in;
   mho_datapath #(.HAS_MUL(1'b1)) dut (
      .core_clk_in(core_clk_in),
      .rst_n_in(rst_n_in),
      .instr_valid_in(instr_valid_in),
      .instr_in(instr_in),
      .pc_in(pc_in),
      .rd_index_in(rd_index_in),
      .rd_data_out(rd_data_out),
      .done_out(done_out),
      .unimpl_exc_out(unimpl_exc_out),
      .illegal_out(illegal_out),
      .wr_en_out(wr_en_out),
      .wr_index_out(wr_index_out),
      .wr_data_out(wr_data_out)
   );
   // same stream into a core built without the multiplier
   mho_datapath #(.HAS_MUL(1'b0)) dut_nomul (
      .core_clk_in(core_clk_in),
      .rst_n_in(rst_n_in),
      .instr_valid_in(instr_valid_in),
      .instr_in(instr_in),
      .pc_in(pc_in),
      .rd_index_in(rd_index_in),
      .rd_data_out(),
      .done_out(nm_done_out),
      .unimpl_exc_out(nm_unimpl_exc_out),
      .illegal_out(),
      .wr_en_out(nm_wr_en_out),
      .wr_index_out(),
      .wr_data_out()
   );
   task automatic print_verdict();
      $display("checks %0d mismatches %0d", total_checks, err_total);
      if (err_total == 0 && total_checks > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   task automatic chk(string n, logic [31:0] e, logic [31:0] g);
      total_checks++;
      if (g !== e) begin
         err_total++;
         $display("MISMATCH %s expected %h seen %h", n, e, g);
      end
   endtask
   function automatic logic [31:0] rw(logic [4:0] a, b, c, logic [5:0] x);
      return {a, b, c, x, 5'h00, mho_pkg::OP_RTYPE};
   endfunction
   // the result pulse lasts one cycle, so it is judged where it stands
   task automatic run(logic [31:0] w, logic we, logic [4:0] ix,
      logic [31:0] d, logic [31:0] p = 32'h0, logic [1:0] xc = 2'h0);
      int n;
      n = 0;
      @(negedge core_clk_in);
      instr_valid_in = 1'b1;
      instr_in = w;
      pc_in = p;
      @(negedge core_clk_in);
      instr_valid_in = 1'b0;
      while (done_out !== 1'b1 && n < 8) begin
         @(negedge core_clk_in);
         n++;
      end
      if (n == 8) chk("done", 32'h1, 32'h0);
      if (n == 8) print_verdict();
      chk("wr_en", {31'h0, we}, {31'h0, wr_en_out});
      chk("exc", {30'h0, xc}, {30'h0, unimpl_exc_out, illegal_out});
      if (we) chk("index", {27'h0, ix}, {27'h0, wr_index_out});
      if (we) chk("data", d, wr_data_out);
   endtask
   // registers are loaded through the next-address path
   task automatic ld(logic [4:0] r, logic [31:0] v);
      run(rw(5'h00, 5'h00, r, mho_pkg::X_NEXTPC), 1'b1, r, v, v - 32'h4);
   endtask
   task automatic t_mul();
      logic [5:0] xs [4] = '{mho_pkg::X_MULXSS, mho_pkg::X_MULXSU,
         mho_pkg::X_MULXUU, mho_pkg::X_MUL};
      logic [31:0] ev [4] = '{32'h1, 32'hffff_ffff, 32'h7fff_ffff, 32'h0};
      logic [31:0] w;
      ld(5'h01, 32'hffff_fffe);
      // top bit set on the second operand splits signed from unsigned
      ld(5'h02, 32'h8000_0000);
      for (int i = 0; i < 4; i++) begin
         w = rw(5'h01, 5'h02, 5'h03, xs[i]);
         run(w, 1'b1, 5'h03, ev[i]);
         chk("nomul_flags", 32'h3, {30'h0, nm_done_out, nm_unimpl_exc_out});
         chk("nomul_wr", 32'h0, {31'h0, nm_wr_en_out});
      end
      $display("multiply test ended");
   endtask
   task automatic t_logic();
      ld(5'h04, 32'h0f0f_00f0);
      ld(5'h05, 32'h00ff_1200);
      run(rw(5'h04, 5'h05, 5'h07, mho_pkg::X_NOR), 1'b1, 5'h07,
         32'hf000_ed0f);
      run(rw(5'h04, 5'h05, 5'h08, mho_pkg::X_OR), 1'b1, 5'h08,
         32'h0fff_12f0);
      run({5'h04, 5'h06, 16'h8001, mho_pkg::OP_ORHI}, 1'b1, 5'h06,
         32'h8f0f_00f0);
      $display("logic test ended");
   endtask
   task automatic t_zero();
      run(rw(5'h00, 5'h00, 5'h00, mho_pkg::X_ADD), 1'b0, 5'h00, 32'h0);
      run(rw(5'h00, 5'h00, 5'h00, mho_pkg::X_NEXTPC), 1'b0, 5'h00, 32'h0);
      run(rw(5'h04, 5'h05, 5'h09, 6'h3f), 1'b0, 5'h09, 32'h0,
         32'h0, 2'h1);
      run({5'h04, 5'h0a, 16'h1234, 6'h14}, 1'b0, 5'h0a, 32'h0,
         32'h0, 2'h1);
      rd_index_in = 5'h00;
      @(negedge core_clk_in);
      chk("r0", 32'h0, rd_data_out);
      rd_index_in = 5'h07;
      @(negedge core_clk_in);
      chk("r7", 32'hf000_ed0f, rd_data_out);
      $display("zero register test ended");
   endtask
   initial begin
      repeat (12) @(posedge core_clk_in);
      @(negedge core_clk_in);
      rst_n_in = 1'b1;
      t_mul();
      t_logic();
      t_zero();
      print_verdict();
   end
endmodule // tb_mul_high_and_logic_ops
